// ---- logic/qgt_pkg.sv ----
// Operation
// R1: Counter follows encoder phase: forward up, reverse down
// R2: Phase counting mode 1 selects edge scheme
// R3: Gate compare-match captures counter into capture register
// R4: Gate compare-match clears gate and quadrature counters
// R5: Host loads measurement interval into gate compare
// R6: Host preloads counter with midpoint before start
// R7: One shared start register runs both channels
// R8: Capture, underflow, overflow interrupts, each enable-gated
// R9: Host reads capture result on capture interrupt
// R10: Host sets overflow error indicator on overflow
// R11: Host sets underflow error indicator on underflow
// R12: Host releases module stop before configuring
// R13: Host selects compare-match capture, not pin edge
// R14: Counter and capture result are 16 bits
// R15: Host clears capture flag, saves value, stops
// R16: Overflow on wrap up, underflow on wrap down
package qgt_pkg;
    localparam int CNT_W = 16;
    localparam logic [7:0] ADDR_STOP = 8'h00;
    localparam logic [7:0] ADDR_START = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_CLRSEL = 8'h0C;
    localparam logic [7:0] ADDR_GATE_CMP = 8'h10;
    localparam logic [7:0] ADDR_GATE_CNT = 8'h14;
    localparam logic [7:0] ADDR_QCNT = 8'h18;
    localparam logic [7:0] ADDR_CAPT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h28;
    localparam int START_GATE_BIT = 0;
    localparam int START_COUNT_BIT = 1;
    localparam int FLAG_CAPT_BIT = 0;
    localparam int FLAG_UNDER_BIT = 1;
    localparam int FLAG_OVER_BIT = 2;
    localparam int CLRSEL_GATE_BIT = 0;
    localparam int CLRSEL_COUNT_BIT = 1;
    localparam int CLRSEL_CAPT_BIT = 2;
    localparam logic [2:0] MODE_PHASE1 = 3'h1;
    localparam logic MSTOP_RST = 1'b1;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] CLRSEL_RST = 3'h0;
    localparam logic [15:0] GATE_CMP_RST = 16'hFFFF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;
    typedef struct packed {
        logic a;
        logic b;
    } phase_t;
endpackage : qgt_pkg

// ---- logic/quadrature_gate_time_counter.sv ----
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module quadrature_gate_time_counter (
    input wire logic clk,
    input wire logic rst,
    input wire qgt_pkg::wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire qgt_pkg::phase_t encoder_in,
    output logic irq
);
    import qgt_pkg::*;

    logic module_stop_r;
    logic [1:0] shared_start_ctrl_r;
    logic [2:0] count_mode_select_r;
    logic [2:0] clear_select_r;
    logic [15:0] gate_interval_compare_r;
    logic [15:0] gate_counter_r;
    logic [CNT_W-1:0] quadrature_counter_r;
    logic [CNT_W-1:0] count_capture_reg_r;
    logic [2:0] count_irq_enables_r;
    logic [2:0] count_irq_flags_r;
    phase_t phase_prev_r;
    logic ack_r;
    logic [31:0] rdata_r;

    logic wr_stb;
    logic rd_hit;
    logic gate_run;
    logic count_run;
    logic gate_match;
    logic step_up;
    logic step_dn;
    logic cnt_over;
    logic cnt_under;
    logic [2:0] set_flags;

    // Ack lasts one cycle so back-to-back strobes are not double-counted
    assign wr_stb = wb_req.cyc && wb_req.stb && wb_req.we && !ack_r;
    assign gate_run = shared_start_ctrl_r[START_GATE_BIT] && !module_stop_r; // [R7]
    assign count_run = shared_start_ctrl_r[START_COUNT_BIT] && !module_stop_r; // [R7]
    assign gate_match = gate_run && (gate_counter_r == gate_interval_compare_r);

    // Mode 1: every edge of either phase counts; direction from the other level
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (count_run && count_mode_select_r == MODE_PHASE1) begin // [R2]
            if (encoder_in.a != phase_prev_r.a) begin
                if (encoder_in.a != encoder_in.b) begin
                    step_up = 1'b1; // [R1]
                end else begin
                    step_dn = 1'b1; // [R1]
                end
            end else if (encoder_in.b != phase_prev_r.b) begin
                if (encoder_in.a == encoder_in.b) begin
                    step_up = 1'b1; // [R1]
                end else begin
                    step_dn = 1'b1; // [R1]
                end
            end
        end
    end

    assign cnt_over = step_up && (quadrature_counter_r == {CNT_W{1'b1}}); // [R16]
    assign cnt_under = step_dn && (quadrature_counter_r == {CNT_W{1'b0}}); // [R16]
    assign set_flags = {cnt_over, cnt_under, gate_match && clear_select_r[CLRSEL_CAPT_BIT]};

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_prev_r <= '0;
        end else begin
            phase_prev_r <= encoder_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            module_stop_r <= MSTOP_RST;
            shared_start_ctrl_r <= 2'h0;
            count_mode_select_r <= MODE_RST;
            clear_select_r <= CLRSEL_RST;
            gate_interval_compare_r <= GATE_CMP_RST;
            count_irq_enables_r <= 3'h0;
        end else if (wr_stb && wb_req.sel[0]) begin
            if (wb_req.adr == ADDR_STOP) begin
                module_stop_r <= wb_req.dat[0];
            end else if (wb_req.adr == ADDR_START) begin
                shared_start_ctrl_r <= wb_req.dat[1:0]; // [R7]
            end else if (wb_req.adr == ADDR_MODE) begin
                count_mode_select_r <= wb_req.dat[2:0];
            end else if (wb_req.adr == ADDR_CLRSEL) begin
                clear_select_r <= wb_req.dat[2:0];
            end else if (wb_req.adr == ADDR_GATE_CMP && wb_req.sel[1]) begin
                gate_interval_compare_r <= wb_req.dat[15:0];
            end else if (wb_req.adr == ADDR_IRQ_EN) begin
                count_irq_enables_r <= wb_req.dat[2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gate_counter_r <= CNT_RST;
        end else if (wr_stb && wb_req.adr == ADDR_GATE_CNT && (&wb_req.sel[1:0])) begin
            gate_counter_r <= wb_req.dat[15:0];
        end else if (gate_match && clear_select_r[CLRSEL_GATE_BIT]) begin
            gate_counter_r <= CNT_RST; // [R4]
        end else if (gate_run) begin
            gate_counter_r <= gate_counter_r + 16'h0001;
        end
    end

    // Preload write wins over counting; host loads midpoint while the gate is stopped
    always_ff @(posedge clk) begin
        if (rst) begin
            quadrature_counter_r <= CNT_RST;
        end else if (wr_stb && wb_req.adr == ADDR_QCNT && (&wb_req.sel[1:0])) begin
            quadrature_counter_r <= wb_req.dat[CNT_W-1:0];
        end else if (gate_match && clear_select_r[CLRSEL_COUNT_BIT]) begin
            quadrature_counter_r <= CNT_RST; // [R4]
        end else if (step_up) begin
            quadrature_counter_r <= quadrature_counter_r + {{(CNT_W-1){1'b0}}, 1'b1}; // [R1] [R14]
        end else if (step_dn) begin
            quadrature_counter_r <= quadrature_counter_r - {{(CNT_W-1){1'b0}}, 1'b1}; // [R1] [R14]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_capture_reg_r <= CNT_RST;
        end else if (gate_match && clear_select_r[CLRSEL_CAPT_BIT]) begin
            count_capture_reg_r <= quadrature_counter_r; // [R3] [R14]
        end
    end

    // Set beats clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            count_irq_flags_r <= 3'h0;
        end else if (wr_stb && wb_req.adr == ADDR_IRQ_CLR && wb_req.sel[0]) begin
            count_irq_flags_r <= (count_irq_flags_r & ~wb_req.dat[2:0]) | set_flags; // [R8] [R16]
        end else begin
            count_irq_flags_r <= count_irq_flags_r | set_flags; // [R8] [R16]
        end
    end

    assign irq = |(count_irq_flags_r & count_irq_enables_r); // [R8]

    assign rd_hit = wb_req.cyc && wb_req.stb && !ack_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= rd_hit;
            rdata_r <= 32'h0;
            if (rd_hit && !wb_req.we) begin
                if (wb_req.adr == ADDR_STOP) begin
                    rdata_r <= {31'h0, module_stop_r};
                end else if (wb_req.adr == ADDR_START) begin
                    rdata_r <= {30'h0, shared_start_ctrl_r};
                end else if (wb_req.adr == ADDR_MODE) begin
                    rdata_r <= {29'h0, count_mode_select_r};
                end else if (wb_req.adr == ADDR_CLRSEL) begin
                    rdata_r <= {29'h0, clear_select_r};
                end else if (wb_req.adr == ADDR_GATE_CMP) begin
                    rdata_r <= {16'h0, gate_interval_compare_r};
                end else if (wb_req.adr == ADDR_GATE_CNT) begin
                    rdata_r <= {16'h0, gate_counter_r};
                end else if (wb_req.adr == ADDR_QCNT) begin
                    rdata_r <= {16'h0, quadrature_counter_r};
                end else if (wb_req.adr == ADDR_CAPT) begin
                    rdata_r <= {16'h0, count_capture_reg_r};
                end else if (wb_req.adr == ADDR_IRQ_EN) begin
                    rdata_r <= {29'h0, count_irq_enables_r};
                end else if (wb_req.adr == ADDR_IRQ_FLAGS) begin
                    rdata_r <= {29'h0, count_irq_flags_r};
                end
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
endmodule : quadrature_gate_time_counter

// ---- tb/qgt_monitor.sv ----
`timescale 1ns/1ps
module qgt_monitor
    import qgt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire qgt_pkg::wb_req_t wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire qgt_pkg::phase_t encoder_in,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_r;
    logic [7:0] adr_r;
    always_ff @(posedge clk) begin
        rd_r <= wb_req.cyc && wb_req.stb && !wb_req.we && !wb_ack_o;
        adr_r <= wb_req.adr;
    end
    ack_answer_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
    irq_reset_a: assert property ($past(rst) |-> !irq) else $error("irq after reset");
    capt_width_a: assert property (wb_ack_o && rd_r && adr_r == ADDR_CAPT |-> wb_dat_o[31:16] == 16'h0)
        else $error("capture too wide");
    count_width_a: assert property (wb_ack_o && rd_r && adr_r == ADDR_QCNT |-> wb_dat_o[31:16] == 16'h0)
        else $error("counter too wide");
    clr_zero_a: assert property (wb_ack_o && rd_r && adr_r == ADDR_IRQ_CLR |-> wb_dat_o == 32'h0)
        else $error("clear reads back");
    unmapped_zero_a: assert property (wb_ack_o && rd_r && adr_r > ADDR_IRQ_CLR |-> wb_dat_o == 32'h0)
        else $error("unmapped read");
    cover property (irq);
    cover property (wb_ack_o && rd_r && adr_r == ADDR_CAPT);
    cover property (wb_ack_o && !rd_r);
endmodule : qgt_monitor
bind quadrature_gate_time_counter qgt_monitor mon (.clk(clk), .rst(rst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .encoder_in(encoder_in), .irq(irq));

// ---- tb/quad_encoder_model.sv ----
`timescale 1ns/1ps
module quad_encoder_model
    import qgt_pkg::*;
(
    input wire logic clk,
    input wire logic fwd,
    input wire logic rev,
    output qgt_pkg::phase_t phase
);
    logic [1:0] pos_r = 2'h0;
    always_ff @(posedge clk) begin
        if (fwd) pos_r <= pos_r + 2'h1;
        else if (rev) pos_r <= pos_r - 2'h1;
    end
    // Gray order, A leads B when turning forward
    assign phase = '{a: pos_r[0] ^ pos_r[1], b: pos_r[1]};
endmodule : quad_encoder_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import qgt_pkg::*;
    logic clk = 1'h0, rst = 1'h1, irq, ack, fwd = 1'h0, rev = 1'h0;
    wb_req_t rq = '0;
    phase_t ph;
    logic [31:0] dat;
    logic [15:0] lf = 16'h2FB0, e;
    int n_fail = 0, tests_run = 0, n;
    always #2.5 clk = ~clk;
    quad_encoder_model enc (.clk(clk), .fwd(fwd), .rev(rev), .phase(ph));
    quadrature_gate_time_counter uut (.clk(clk), .rst(rst), .wb_req(rq), .wb_dat_o(dat), .wb_ack_o(ack),
        .encoder_in(ph), .irq(irq));
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nx
    function automatic logic [15:0] moved(input logic [15:0] v, input logic d);
        return d ? v + 16'h1 : v - 16'h1;
    endfunction : moved
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k = 0;
        rq <= '{1'h1, 1'h1, w, a, 4'hF, d};
        do @(posedge clk); while (ack !== 1'h1 && ++k < 50);
        if (k >= 50) n_fail++;
        q = dat;
        rq <= '0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        chk(q, x);
    endtask : rd
    task automatic step(input logic d);
        fwd <= d;
        rev <= !d;
        @(posedge clk);
        fwd <= 1'h0;
        rev <= 1'h0;
        lf = nx(lf);
        repeat (3 + lf[1:0]) @(posedge clk);
    endtask : step
    task automatic tally_and_finish;
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        #60000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        rd(ADDR_STOP, 32'h1);
        rd(ADDR_GATE_CMP, 32'hFFFF);
        rd(8'h2C, 32'h0);
        wr(ADDR_STOP, 32'h0);
        wr(ADDR_START, 32'h2);
        step(1'h1);
        rd(ADDR_QCNT, 32'h0);
        wr(ADDR_MODE, {29'h0, MODE_PHASE1});
        wr(ADDR_QCNT, 32'hFFFF);
        step(1'h1);
        rd(ADDR_QCNT, 32'h0);
        rd(ADDR_IRQ_FLAGS, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_EN, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h7);
        step(1'h0);
        rd(ADDR_QCNT, 32'hFFFF);
        rd(ADDR_IRQ_FLAGS, 32'h2);
        wr(ADDR_IRQ_CLR, 32'h7);
        rd(ADDR_IRQ_CLR, 32'h0);
        wr(ADDR_CLRSEL, 32'h7);
        wr(ADDR_GATE_CMP, 32'h40);
        wr(ADDR_QCNT, 32'h8000);
        wr(ADDR_IRQ_EN, 32'h7);
        e = 16'h8000;
        for (n = 0; n < 24; n++) begin
            step(lf[5]);
            e = moved(e, lf[5]);
        end
        rd(ADDR_QCNT, {16'h0, e});
        wr(ADDR_START, 32'h3);
        n = 0;
        while (irq !== 1'h1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n >= 500) n_fail++;
        rd(ADDR_CAPT, {16'h0, e});
        rd(ADDR_QCNT, 32'h0);
        rd(ADDR_IRQ_FLAGS, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h1);
        wr(ADDR_START, 32'h0);
        chk({31'h0, irq}, 32'h0);
        tally_and_finish;
    end
endmodule : tb_top
